// >>> include/p0fs_pkg.sv
// p0fs_pkg: constants for the port 0 pin function select block.
// assumes a 32-bit apb slave with word-aligned registers at byte offsets.
`default_nettype none
package p0fs_pkg;
	// bus geometry
	localparam int ADDR_W      = 12;          // decoded address bits
	localparam int DATA_W      = 32;          // apb data width
	localparam int HALF_W      = 16;          // selector / mask halfword
	localparam int NUM_WORDS   = 4;           // control words a to d
	localparam int SEL_W       = 2;           // selector field width
	localparam int MASK_LSB    = 16;          // first write-mask bit

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_PORT_A = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_PORT_B = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_PORT_C = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_PORT_D = 12'h00c;
	localparam logic [NUM_WORDS-1:0][ADDR_W-1:0] OFFSETS =
		{OFF_PORT_D, OFF_PORT_C, OFF_PORT_B, OFF_PORT_A};

	// implemented (read-write) bits of each lower halfword
	localparam logic [HALF_W-1:0] IMPL_PORT_A = 16'hc333;
	localparam logic [HALF_W-1:0] IMPL_PORT_B = 16'h0000;
	localparam logic [HALF_W-1:0] IMPL_PORT_C = 16'h0000;
	localparam logic [HALF_W-1:0] IMPL_PORT_D = 16'h30c0;
	localparam logic [NUM_WORDS-1:0][HALF_W-1:0] IMPL_MASK =
		{IMPL_PORT_D, IMPL_PORT_C, IMPL_PORT_B, IMPL_PORT_A};

	// reset value of every stored halfword and of the mask field
	localparam logic [HALF_W-1:0] RST_HALF = 16'h0000;

	// word index of ports a and d
	localparam int IDX_A = 0;
	localparam int IDX_D = 3;

	// selector field positions (lsb)
	localparam int POS_A7 = 14;
	localparam int POS_A4 = 8;
	localparam int POS_A2 = 4;
	localparam int POS_A0 = 0;
	localparam int POS_D6 = 12;
	localparam int POS_D3 = 6;

	// selector codes
	localparam logic [SEL_W-1:0] CODE_GPIO = 2'h0;
	localparam logic [SEL_W-1:0] CODE_ALT1 = 2'h1;
	localparam logic [SEL_W-1:0] CODE_ALT2 = 2'h2;
	localparam logic [SEL_W-1:0] CODE_ALT3 = 2'h3;
endpackage
`default_nettype wire

// >>> rtl/p0fs_top.sv
// p0fs_top: apb register slave for the port 0 pin function selectors.
// assumes apb master on mclk_in, full 32-bit word accesses only, and pad
// multiplexers that sample the registered route and enable outputs.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module p0fs_top (
	input  wire logic        mclk_in,                  // 20 mhz bus clock
	input  wire logic        sys_rst_in,               // sync reset, high
	input  wire logic        psel_in,                  // apb select
	input  wire logic        penable_in,               // apb access phase
	input  wire logic        pwrite_in,                // apb direction
	input  wire logic [11:0] paddr_in,                 // apb byte address
	input  wire logic [31:0] pwdata_in,                // apb write data
	output var  logic [31:0] prdata_out,               // apb read data
	output logic             pready_out,               // apb ready
	output logic             pslverr_out,              // apb error
	output var  logic [1:0]  pin_a7_route_out,         // pin a7 selector
	output var  logic [1:0]  pin_a4_route_out,         // pin a4 selector
	output var  logic [1:0]  pin_a2_route_out,         // pin a2 selector
	output var  logic [1:0]  pin_a0_route_out,         // pin a0 selector
	output var  logic [1:0]  pin_d6_route_out,         // pin d6 selector
	output var  logic [1:0]  pin_d3_route_out,         // pin d3 selector
	output var  logic        managed_flash_data0_out,  // a7 on flash data0
	output var  logic        hot_plug_detect_out,      // a4 on hot plug
	output var  logic        ethernet_clock_out_route0_out, // a2 mac clk
	output var  logic        digital_audio_out_route2_out,  // a2 audio
	output var  logic        wireless_clock_out_route0_out, // a0 wifi clk
	output var  logic        phy_led_low_speed_out,    // d6 speed led
	output var  logic        phy_led_duplex_out,       // d6 duplex led
	output var  logic        card_power_enable_route1_out,  // d6 power
	output var  logic        digital_audio_out_route0_out,  // d3 audio
	output var  logic [5:0]  pin_gpio_mode_out         // a7,a4,a2,a0,d6,d3
);

	// stored lower halfwords, one per control word
	// only the lower halfword of each word is kept; the mask half is
	// used on the fly. reserved positions are forced to zero by the
	// implemented-bit mask, so no separate read-only logic is needed
	logic [15:0] ctrl [0:3];                 // current selector bits
	logic [15:0] next_ctrl [0:3];            // value after this edge
	logic [3:0]  word_hit;                   // address matches word w
	logic        addr_mapped;                // any word matched
	logic        setup_phase;                // apb setup cycle
	logic        access_phase;               // apb access cycle
	logic        wr_access;                  // write takes effect now
	logic [15:0] wr_mask;                    // per-bit write enable
	logic [15:0] rd_half;                    // selected word, lower half
	logic [31:0] next_rdata;                 // read word for capture
	logic        err_q;                      // latched unmapped flag

	// apb phase decode
	// pready is tied high: every register is a plain flop, so there is
	// nothing to wait for, and a master that polls pready still works
	// because the access phase simply ends at its first edge
	assign setup_phase  = psel_in & ~penable_in;
	assign access_phase = psel_in & penable_in;
	// zero wait states: every access ends in its first access cycle
	assign wr_access    = access_phase & pwrite_in & addr_mapped;

	// the mask half only gates this one write and is never stored,
	// so a later read cannot see it
	assign wr_mask = pwdata_in[31:16];

	// per-word storage, write merge and address match
	genvar w;
	generate
		for (w = 0; w < p0fs_pkg::NUM_WORDS; w = w + 1) begin : g_word
			// exact match also rejects unaligned addresses
			assign word_hit[w] = (paddr_in == p0fs_pkg::OFFSETS[w]);

			// masked merge; only implemented bits can ever be one,
			// which keeps reserved positions at zero for ports b to d
			// and for the gaps in a and d
			assign next_ctrl[w] = (wr_access & word_hit[w]) ?
				(((ctrl[w] & ~wr_mask) |
				  (pwdata_in[15:0] & wr_mask)) &
				 p0fs_pkg::IMPL_MASK[w]) :
				ctrl[w];

			// one register per word, cleared to gpio on reset
			always_ff @(posedge mclk_in) begin
				if (sys_rst_in) begin
					ctrl[w] <= p0fs_pkg::RST_HALF;
				end else begin
					// whole-word data arrives with its mask
					ctrl[w] <= next_ctrl[w];
				end
			end
		end
	endgenerate

	// an access outside the four words is flagged through pslverr;
	// writes there are dropped and reads there return zero
	assign addr_mapped = |word_hit;

	// read mux; unmapped words read as zero
	// the word hits are one-hot by construction, so the priority order
	// of this chain never matters; it only keeps the decode readable
	assign rd_half =
		word_hit[0] ? ctrl[0] :
		word_hit[1] ? ctrl[1] :
		word_hit[2] ? ctrl[2] :
		word_hit[3] ? ctrl[3] :
		p0fs_pkg::RST_HALF;

	// mask field always reads zero
	assign next_rdata = {p0fs_pkg::RST_HALF, rd_half};

	// read data and error flag are captured in the setup cycle so
	// that prdata comes from a flop; a write in the same transfer
	// cannot disturb them since apb allows one transfer at a time
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			prdata_out <= 32'h0000_0000;
			err_q      <= 1'b0;
		end else if (setup_phase) begin
			prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
			err_q      <= ~addr_mapped;
		end
	end

	// handshake: always ready, error only on an unmapped access
	assign pready_out  = 1'b1;
	assign pslverr_out = access_phase & err_q;

	// selector views of the stored words
	// the views read next_ctrl, not ctrl, so the pad flops below load
	// the new code on the very edge that the write lands on; reading
	// ctrl instead would add a cycle of lag between software and pads
	logic [1:0] next_a7;                     // pin a7 next code
	logic [1:0] next_a4;                     // pin a4 next code
	logic [1:0] next_a2;                     // pin a2 next code
	logic [1:0] next_a0;                     // pin a0 next code
	logic [1:0] next_d6;                     // pin d6 next code
	logic [1:0] next_d3;                     // pin d3 next code

	assign next_a7 = next_ctrl[p0fs_pkg::IDX_A][p0fs_pkg::POS_A7 +: 2];
	assign next_a4 = next_ctrl[p0fs_pkg::IDX_A][p0fs_pkg::POS_A4 +: 2];
	assign next_a2 = next_ctrl[p0fs_pkg::IDX_A][p0fs_pkg::POS_A2 +: 2];
	assign next_a0 = next_ctrl[p0fs_pkg::IDX_A][p0fs_pkg::POS_A0 +: 2];
	assign next_d6 = next_ctrl[p0fs_pkg::IDX_D][p0fs_pkg::POS_D6 +: 2];
	assign next_d3 = next_ctrl[p0fs_pkg::IDX_D][p0fs_pkg::POS_D3 +: 2];

	// decoded function enables; a reserved code enables nothing, so
	// the pin falls back to gpio rather than to an undefined route
	logic next_flash;                        // a7 flash data0
	logic next_hpd;                          // a4 hot plug detect
	logic next_mac_clk;                      // a2 ethernet clock
	logic next_audio2;                       // a2 audio route2
	logic next_wifi_clk;                     // a0 wireless clock
	logic next_led_spd;                      // d6 speed led
	logic next_led_dup;                      // d6 duplex led
	logic next_card_pwr;                     // d6 card power
	logic next_audio0;                       // d3 audio route0
	logic [5:0] next_gpio;                   // per-pin gpio mode

	// port a routes
	// codes not listed for a pin are reserved and decode to no route;
	// each pin can have at most one alternate function active at once
	assign next_flash    = (next_a7 == p0fs_pkg::CODE_ALT2);
	assign next_hpd      = (next_a4 == p0fs_pkg::CODE_ALT1);
	assign next_mac_clk  = (next_a2 == p0fs_pkg::CODE_ALT1);
	assign next_audio2   = (next_a2 == p0fs_pkg::CODE_ALT2);
	assign next_wifi_clk = (next_a0 == p0fs_pkg::CODE_ALT1);
	// port d6: every code is a valid route
	assign next_led_spd  = (next_d6 == p0fs_pkg::CODE_ALT1);
	assign next_led_dup  = (next_d6 == p0fs_pkg::CODE_ALT2);
	assign next_card_pwr = (next_d6 == p0fs_pkg::CODE_ALT3);
	// port d3: codes 10 and 11 leave the pin on gpio
	assign next_audio0   = (next_d3 == p0fs_pkg::CODE_ALT1);

	// gpio whenever no alternate function is active
	assign next_gpio[5] = ~next_flash;
	assign next_gpio[4] = ~next_hpd;
	assign next_gpio[3] = ~(next_mac_clk | next_audio2);
	assign next_gpio[2] = ~next_wifi_clk;
	assign next_gpio[1] = ~(next_led_spd | next_led_dup | next_card_pwr);
	assign next_gpio[0] = ~next_audio0;

	// pad control flops, updated on the same edge as the registers so
	// the route outputs never lag software by a cycle
	// each output has its own short flop so a slip on one route cannot
	// hide inside a long shared block; all of them clear to gpio with
	// every alternate function disabled

	// pin a7 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_a7_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_a7_route_out <= next_a7;
		end
	end

	// pin a4 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_a4_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_a4_route_out <= next_a4;
		end
	end

	// pin a2 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_a2_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_a2_route_out <= next_a2;
		end
	end

	// pin a0 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_a0_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_a0_route_out <= next_a0;
		end
	end

	// pin d6 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_d6_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_d6_route_out <= next_d6;
		end
	end

	// pin d3 selector copy
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_d3_route_out <= p0fs_pkg::CODE_GPIO;
		end else begin
			pin_d3_route_out <= next_d3;
		end
	end

	// a7 flash data0 enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			managed_flash_data0_out <= 1'b0;
		end else begin
			managed_flash_data0_out <= next_flash;
		end
	end

	// a4 hot plug detect enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			hot_plug_detect_out <= 1'b0;
		end else begin
			hot_plug_detect_out <= next_hpd;
		end
	end

	// a2 ethernet clock enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ethernet_clock_out_route0_out <= 1'b0;
		end else begin
			ethernet_clock_out_route0_out <= next_mac_clk;
		end
	end

	// a2 audio route2 enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			digital_audio_out_route2_out <= 1'b0;
		end else begin
			digital_audio_out_route2_out <= next_audio2;
		end
	end

	// a0 wireless clock enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wireless_clock_out_route0_out <= 1'b0;
		end else begin
			wireless_clock_out_route0_out <= next_wifi_clk;
		end
	end

	// d6 speed led enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			phy_led_low_speed_out <= 1'b0;
		end else begin
			phy_led_low_speed_out <= next_led_spd;
		end
	end

	// d6 duplex led enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			phy_led_duplex_out <= 1'b0;
		end else begin
			phy_led_duplex_out <= next_led_dup;
		end
	end

	// d6 card power enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			card_power_enable_route1_out <= 1'b0;
		end else begin
			card_power_enable_route1_out <= next_card_pwr;
		end
	end

	// d3 audio route0 enable
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			digital_audio_out_route0_out <= 1'b0;
		end else begin
			digital_audio_out_route0_out <= next_audio0;
		end
	end

	// per-pin gpio mode flags, all pins on gpio after reset
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pin_gpio_mode_out <= 6'h3f;
		end else begin
			pin_gpio_mode_out <= next_gpio;
		end
	end

endmodule
`default_nettype wire

// >>> testbench/p0fs_checker.sv
// p0fs_checker: concurrent checks on the pin function select ports.
// assumes a bind to p0fs_top and whole-word apb accesses.
`timescale 1ns/10ps
`default_nettype none
module p0fs_checker (
	input wire logic        mclk_in,      // bus clock
	input wire logic        sys_rst_in,   // sync reset, high
	input wire logic        psel_in,      // apb select
	input wire logic        penable_in,   // apb access phase
	input wire logic        pwrite_in,    // apb direction
	input wire logic [11:0] paddr_in,     // apb byte address
	input wire logic [31:0] pwdata_in,    // mask and data
	input wire logic [31:0] prdata_out,   // read data
	input wire logic        pslverr_out,  // error flag
	input wire logic [1:0]  pin_a7_route_out, // a7 selector
	input wire logic [1:0]  pin_d6_route_out, // d6 selector
	input wire logic [1:0]  pin_d3_route_out, // d3 selector
	input wire logic        phy_led_duplex_out, // d6 duplex led
	input wire logic        digital_audio_out_route0_out // d3 audio
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// one read: setup then access, so prdata is the captured word
	sequence s_read;
		psel_in && !penable_in && !pwrite_in ##1 psel_in && penable_in;
	endsequence
	// write to port a in its access phase
	wire wr_a = psel_in && penable_in && pwrite_in && paddr_in == 12'h000;
	a_mask_reads_zero:
		assert property (s_read ##0 !pslverr_out |-> prdata_out[31:16] == 0)
		else $error("mask half reads nonzero");
	a_port_b_zero:
		assert property (s_read ##0 paddr_in == 12'h004 |-> prdata_out == 0)
		else $error("port b word nonzero");
	a_port_c_zero:
		assert property (s_read ##0 paddr_in == 12'h008 |-> prdata_out == 0)
		else $error("port c word nonzero");
	a_port_a_rsv:
		assert property (s_read ##0 paddr_in == 12'h000 |->
			(prdata_out & 32'hffff_3ccc) == 0) else $error("port a rsv set");
	a_port_d_rsv:
		assert property (s_read ##0 paddr_in == 12'h00c |->
			(prdata_out & 32'hffff_cf3f) == 0) else $error("port d rsv set");
	a_masked_hold:
		assert property (wr_a && pwdata_in[31:30] == 2'h0 |=>
			$stable(pin_a7_route_out)) else $error("masked a7 changed");
	a_unmasked_load:
		assert property (wr_a && pwdata_in[31:30] == 2'h3 |=>
			pin_a7_route_out == $past(pwdata_in[15:14]))
		else $error("a7 not loaded");
	a_duplex_decode:
		assert property (phy_led_duplex_out == (pin_d6_route_out == 2'h2))
		else $error("duplex led decode wrong");
	a_audio_decode:
		assert property (digital_audio_out_route0_out ==
			(pin_d3_route_out == 2'h1))
		else $error("d3 audio decode wrong");
endmodule
`default_nettype wire

// >>> testbench/tb_p0fs_top.sv
// tb_p0fs_top: self-checking bench for the pin function select block.
// assumes an apb slave on mclk_in; expectations come from the map.
`timescale 1ns/10ps
`default_nettype none
module tb_p0fs_top;
	logic        mclk_in = 1'b0;   // 20 mhz clock
	logic        sys_rst_in = 1'b1; // reset, held at start
	logic        psel_in = 1'b0;   // apb select
	logic        penable_in = 1'b0; // apb access
	logic        pwrite_in = 1'b0; // apb direction
	logic [11:0] paddr_in = 12'h000; // apb address
	logic [31:0] pwdata_in = 32'h0000_0000; // mask and data
	wire logic [31:0] prdata_out; // read data
	wire logic pready_out, pslverr_out, flash0, speed, duplex, power, aud0;
	wire logic [1:0] a7, d6, d3;  // selector copies
	wire logic [1:0] a4, a2, a0;  // port a low selector copies
	wire logic hpd, macclk, aud2, wifi; // port a route enables
	wire logic [5:0] gmode;       // gpio mode flags
	logic [31:0] rdat;            // last read word
	logic        rerr;            // last error flag
	int          err_count = 0;   // mismatches
	int          cmp_count = 0;   // comparisons
	p0fs_top uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.pin_a7_route_out(a7), .pin_a4_route_out(a4), .pin_a2_route_out(a2),
		.pin_a0_route_out(a0), .pin_d6_route_out(d6), .pin_d3_route_out(d3),
		.managed_flash_data0_out(flash0), .hot_plug_detect_out(hpd),
		.ethernet_clock_out_route0_out(macclk),
		.digital_audio_out_route2_out(aud2),
		.wireless_clock_out_route0_out(wifi), .phy_led_low_speed_out(speed),
		.phy_led_duplex_out(duplex), .card_power_enable_route1_out(power),
		.digital_audio_out_route0_out(aud0), .pin_gpio_mode_out(gmode));
	// free-running clock, 50 ns period
	always #25 mclk_in = ~mclk_in;
	task end_of_test;
		$display("mismatches %0d, compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; the answer is taken at the edge where pready is
	// sampled high, and only then is the request released
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
			rdy = pready_out;
		end while (rdy !== 1'b1 && n < 16);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (rdy !== 1'b1) begin
			err_count++;
			end_of_test();
		end
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	// reset values of all words and pins
	task t_reset;
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h004, 32'h0000_0000);
		rdc(12'h008, 32'h0000_0000);
		rdc(12'h00c, 32'h0000_0000);
		chk({26'h0, gmode}, 32'h0000_003f);
	endtask
	// per-bit write mask on port a, plus an unmapped read
	task t_mask;
		apb(1'b1, 12'h000, 32'hffff_ffff);
		rdc(12'h000, 32'h0000_c333);
		apb(1'b1, 12'h000, 32'h0000_0000);
		rdc(12'h000, 32'h0000_c333);
		apb(1'b1, 12'h000, 32'h4000_0000);
		rdc(12'h000, 32'h0000_8333);
		chk({28'h0, gmode[5], a7, flash0}, 32'h0000_0005);
		rdc(12'h010, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001);
	endtask
	// every code of the three low port a selectors, a7 masked off
	task t_port_a;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			apb(1'b1, 12'h000, {16'h0333, 6'h0, c, 2'h0, c, 2'h0, c});
			rdc(12'h000, {18'h2, 4'h0, c, 2'h0, c, 2'h0, c});
			chk({26'h0, a4, a2, a0}, {26'h0, c, c, c});
			chk({28'h0, hpd, macclk, aud2, wifi},
				{28'h0, c == 2'h1, c == 2'h1, c == 2'h2, c == 2'h1});
			chk({29'h0, gmode[4:2]},
				{29'h0, c != 2'h1, c[0] == c[1], c != 2'h1});
		end
	endtask
	// a reset in mid-run clears every word and pin again
	task t_rerun;
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_reset();
	endtask
	// reserved words stay zero
	task t_rsv;
		apb(1'b1, 12'h004, 32'hffff_ffff);
		rdc(12'h004, 32'h0000_0000);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		rdc(12'h008, 32'h0000_0000);
	endtask
	// every code of both port d selectors
	task t_codes;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			apb(1'b1, 12'h00c, {16'hffff, 2'h0, c, 4'h0, c, 6'h3f});
			rdc(12'h00c, {18'h0, c, 4'h0, c, 6'h00});
			chk({28'h0, speed, duplex, power, gmode[1]},
				{28'h0, c == 2'h1, c == 2'h2, c == 2'h3, c == 2'h0});
			chk({29'h0, d3, aud0}, {29'h0, c, c == 2'h1});
			chk({31'h0, gmode[0]}, {31'h0, c != 2'h1});
			chk({30'h0, d6}, {30'h0, c});
		end
	endtask
	initial begin
		repeat (20) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_mask();
		t_port_a();
		t_rsv();
		t_codes();
		t_rerun();
		end_of_test();
	end
endmodule
bind p0fs_top p0fs_checker chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pslverr_out(pslverr_out), .pin_a7_route_out(pin_a7_route_out),
	.pin_d6_route_out(pin_d6_route_out), .pin_d3_route_out(pin_d3_route_out),
	.phy_led_duplex_out(phy_led_duplex_out),
	.digital_audio_out_route0_out(digital_audio_out_route0_out));
`default_nettype wire
